// [logic/dhb_pkg.sv]
// constants of the disk controller host bus interface
package dhb_pkg;
  localparam int          RS_W         = 6;
  localparam int          FIFO_DEPTH   = 32;
  // control register index (register select value)
  localparam logic [5:0]  REG_FIFO     = 6'h00;
  localparam logic [5:0]  REG_CTRL     = 6'h01;
  localparam logic [5:0]  REG_STATUS   = 6'h02;
  localparam logic [5:0]  REG_ADDR0    = 6'h03;
  localparam logic [5:0]  REG_ADDR1    = 6'h04;
  localparam logic [5:0]  REG_ADDR2    = 6'h05;
  localparam logic [5:0]  REG_ADDR3    = 6'h06;
  localparam logic [5:0]  REG_THRESH   = 6'h07;
  localparam logic [5:0]  REG_IMASK    = 6'h08;
  localparam logic [5:0]  REG_ID       = 6'h3F;
  // control bit positions
  localparam int          CTL_DMA_EN   = 0;
  localparam int          CTL_MASTER   = 1;
  localparam int          CTL_WORD     = 2;
  localparam int          CTL_ADDR32   = 3;
  localparam int          CTL_TO_MEM   = 4;
  localparam int          CTL_SEND_IN  = 5;
  localparam int          CTL_SEND_OUT = 6;
  localparam int          CTL_TRACK    = 7;
  // event and fifo flag bit positions in status
  localparam int          EV_ERROR     = 0;
  localparam int          EV_CMD_DONE  = 1;
  localparam int          EV_CORR_DONE = 2;
  localparam int          EV_HDR_DONE  = 3;
  localparam int          ST_EMPTY     = 4;
  localparam int          ST_FULL      = 5;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [7:0]  THRESH_RST   = 8'h02;
  localparam logic [7:0]  ID_VALUE     = 8'h5A;
  typedef enum logic [2:0] {DHB_IDLE, DHB_ADDR_HI, DHB_ADDR_LO, DHB_DATA, DHB_END} dhb_state_t;
endpackage

// [logic/dhb_host_bus.sv]
// host bus port of the disk data controller: register access, fifo, dma
// Contract
// - select low, dma idle: act as port
// - ignore select during on-chip dma transfer
// - interrupt on error, command, correction, header
// - reset empties fifo, clears status, halts dma
// - processor read puts register on low lines
// - processor write captures low lines into register
// - slave mode moves bus data through fifo
// - master mode drives read, write strobes
// - bus clock times all master activity
// - remote grant drop finishes current cycle
// - local grant wins, drop finishes cycle
// - register select addresses registers when selected
// - select high, dma idle: float low lines
// - processor access drives upper lines anyway
// - master mode multiplexes address and data
// - local request raised when fifo needs service; the code holds it low while the track bit is set or a dma cycle runs
// - low address strobe latches register select
// - low address strobe output during dma
// - high address strobe in 32-bit mode
// - remote request follows send bits or tracking
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dhb_host_bus #(
  parameter int DEPTH = dhb_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        port_select_n,
  input  wire logic [5:0]  reg_select,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  output logic             rd_n_out,
  output logic             wr_n_out,
  output logic             strobe_oe,
  input  wire logic        remote_grant,
  input  wire logic        local_grant,
  input  wire logic [15:0] ad_in,
  output logic [15:0]      ad_out,
  output logic             ad_low_oe,
  output logic             ad_high_oe,
  input  wire logic        low_addr_strobe_in,
  output logic             low_addr_strobe_out,
  output logic             low_addr_strobe_oe,
  output logic             high_addr_strobe,
  output logic             local_request,
  output logic             int_n,
  input  wire logic [3:0]  event_pulse,
  input  wire logic        disk_push,
  input  wire logic [7:0]  disk_wdata,
  input  wire logic        disk_pop,
  output logic [7:0]       disk_rdata,
  output logic             fifo_empty,
  output logic             fifo_full
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
      $error("fifo depth must be a power of two of at least 4");
  end

  logic [7:0]       fifo_mem [DEPTH];
  logic [AW:0]      count;
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [7:0]       ctrl;
  logic [7:0]       thresh;
  logic [7:0]       imask;
  logic [3:0]       events;
  logic [31:0]      dma_addr;
  logic [5:0]       rs_latch;
  logic             rd_q;
  logic             wr_q;
  dhb_pkg::dhb_state_t state;
  dhb_pkg::dhb_state_t next_state;

  // on-chip dma owns the bus while a cycle runs
  wire dma_busy   = (state != dhb_pkg::DHB_IDLE);
  wire master_en  = ctrl[dhb_pkg::CTL_DMA_EN] && ctrl[dhb_pkg::CTL_MASTER];
  wire to_mem     = ctrl[dhb_pkg::CTL_TO_MEM];
  wire word_mode  = ctrl[dhb_pkg::CTL_WORD];
  wire any_grant  = local_grant || remote_grant;
  wire cpu_mode   = !port_select_n && !any_grant && !dma_busy;
  wire slave_mode = local_grant && !master_en && !dma_busy;
  wire rd_edge    = rd_q && !rd_n_in;
  wire wr_edge    = wr_q && !wr_n_in;
  wire [5:0] rs_eff = low_addr_strobe_in ? reg_select : rs_latch;
  wire sel_fifo   = rs_eff == dhb_pkg::REG_FIFO;
  wire cpu_wr     = cpu_mode && wr_edge;
  wire cpu_rd     = cpu_mode && rd_edge;
  wire slave_wr   = slave_mode && wr_edge;
  wire slave_rd   = slave_mode && rd_edge;
  wire dma_data   = state == dhb_pkg::DHB_DATA;
  wire fifo_wr_bus = (cpu_wr && sel_fifo) || slave_wr || (dma_data && !to_mem);
  wire fifo_rd_bus = (cpu_rd && sel_fifo) || slave_rd || (dma_data && to_mem);
  wire two_bytes  = word_mode && !cpu_mode;
  wire [1:0] nbytes = two_bytes ? 2'd2 : 2'd1;
  wire [AW:0] push_n = (two_bytes && !disk_push) ? (AW+1)'(2) : (AW+1)'(1);
  wire [AW:0] pop_n  = (two_bytes && !disk_pop) ? (AW+1)'(2) : (AW+1)'(1);
  wire [AW:0] space = (AW+1)'(DEPTH) - count;
  // room and fill checked per transfer width, a word never half lands
  wire push       = (fifo_wr_bus || disk_push) && (space >= push_n);
  wire pop        = (fifo_rd_bus || disk_pop) && (count >= pop_n);
  wire [AW:0] next_count = count + (push ? push_n : '0) - (pop ? pop_n : '0);
  wire need_svc   = ctrl[dhb_pkg::CTL_DMA_EN] &&
                    (to_mem ? (count >= (AW+1)'(thresh)) : (space >= (AW+1)'(thresh)));
  wire [7:0] fifo_head = fifo_mem[rptr];
  wire [7:0] fifo_next = fifo_mem[rptr + AW'(1)];
  wire [7:0] status = {2'b00, fifo_full, fifo_empty, events};
  wire [7:0] reg_rd =
    sel_fifo                          ? fifo_head :
    rs_eff == dhb_pkg::REG_CTRL       ? ctrl :
    rs_eff == dhb_pkg::REG_STATUS     ? status :
    rs_eff == dhb_pkg::REG_ADDR0      ? dma_addr[7:0] :
    rs_eff == dhb_pkg::REG_ADDR1      ? dma_addr[15:8] :
    rs_eff == dhb_pkg::REG_ADDR2      ? dma_addr[23:16] :
    rs_eff == dhb_pkg::REG_ADDR3      ? dma_addr[31:24] :
    rs_eff == dhb_pkg::REG_THRESH     ? thresh :
    rs_eff == dhb_pkg::REG_IMASK      ? {4'h0, imask[3:0]} :
    rs_eff == dhb_pkg::REG_ID         ? dhb_pkg::ID_VALUE : 8'h00;
  wire remote_track = ctrl[dhb_pkg::CTL_TRACK];
  wire remote_send  = ctrl[dhb_pkg::CTL_SEND_IN] || ctrl[dhb_pkg::CTL_SEND_OUT];
  wire next_remote_req = remote_track ? (remote_grant && dma_busy) : remote_send;
  wire addr32       = ctrl[dhb_pkg::CTL_ADDR32];
  wire dma_start    = master_en && need_svc && any_grant &&
                      (to_mem ? !fifo_empty : !fifo_full);

  // transfer cycle; grant sampled only at start
  always_comb
  begin
    next_state = state;
    unique case (state)
      dhb_pkg::DHB_IDLE:    if (dma_start)
                              next_state = addr32 ? dhb_pkg::DHB_ADDR_HI : dhb_pkg::DHB_ADDR_LO;
      dhb_pkg::DHB_ADDR_HI: next_state = dhb_pkg::DHB_ADDR_LO;
      dhb_pkg::DHB_ADDR_LO: next_state = dhb_pkg::DHB_DATA;
      dhb_pkg::DHB_DATA:    next_state = dhb_pkg::DHB_END;
      dhb_pkg::DHB_END:     next_state = dhb_pkg::DHB_IDLE;
      default:              next_state = dhb_pkg::DHB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    rd_q <= rd_n_in;
    wr_q <= wr_n_in;
    if (!low_addr_strobe_in)
      rs_latch <= rs_latch;
    else
      rs_latch <= reg_select;
  end

  // reset halts dma, clears fifo and status; config kept
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      state <= dhb_pkg::DHB_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys)
  begin
    // reset halts dma; other control bits kept
    if (srst)
      ctrl[dhb_pkg::CTL_DMA_EN] <= 1'b0;
    else if (cpu_wr && rs_eff == dhb_pkg::REG_CTRL)
      ctrl <= ad_in[7:0];
    if (cpu_wr && rs_eff == dhb_pkg::REG_THRESH)
      thresh <= ad_in[7:0];
    if (cpu_wr && rs_eff == dhb_pkg::REG_IMASK)
      imask <= ad_in[7:0];
    if (cpu_wr && rs_eff == dhb_pkg::REG_ADDR0)
      dma_addr[7:0] <= ad_in[7:0];
    else if (cpu_wr && rs_eff == dhb_pkg::REG_ADDR1)
      dma_addr[15:8] <= ad_in[7:0];
    else if (cpu_wr && rs_eff == dhb_pkg::REG_ADDR2)
      dma_addr[23:16] <= ad_in[7:0];
    else if (cpu_wr && rs_eff == dhb_pkg::REG_ADDR3)
      dma_addr[31:24] <= ad_in[7:0];
    else if (state == dhb_pkg::DHB_END)
      dma_addr <= dma_addr + {30'h0, nbytes};
  end

  // sticky events, set wins over write-one clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      events <= 4'h0;
    else
      events <= event_pulse |
                (events & ~((cpu_wr && rs_eff == dhb_pkg::REG_STATUS) ? ad_in[3:0] : 4'h0));
  end

  // fifo storage and pointers
  always_ff @(posedge clk_sys)
  begin
    if (push)
      fifo_mem[wptr] <= disk_push ? disk_wdata : ad_in[7:0];
    if (push && two_bytes && !disk_push)
      fifo_mem[wptr + AW'(1)] <= ad_in[15:8];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end
    else
    begin
      wptr  <= wptr + (push ? push_n[AW-1:0] : AW'(0));
      rptr  <= rptr + (pop ? pop_n[AW-1:0] : AW'(0));
      count <= next_count;
    end
  end

  // bus word by phase
  // bus word and enables follow the same phase as the strobes
  wire next_busy  = next_state != dhb_pkg::DHB_IDLE;
  wire next_data  = next_state == dhb_pkg::DHB_DATA;
  wire [15:0] next_ad =
    next_state == dhb_pkg::DHB_ADDR_HI ? dma_addr[31:16] :
    next_state == dhb_pkg::DHB_ADDR_LO ? dma_addr[15:0] :
    next_data                          ? {fifo_next, fifo_head} :
    // register data, upper byte driven anyway
    {8'h00, reg_rd};
  // float when not selected and idle
  wire next_low_oe  = (cpu_mode && !rd_n_in) || (slave_mode && !rd_n_in) ||
                      (next_busy && !(next_data && !to_mem));
  wire next_high_oe = cpu_mode || (slave_mode && !rd_n_in && word_mode) ||
                      (next_busy && !(next_data && !to_mem));

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ad_out              <= 16'h0000;
      ad_low_oe           <= 1'b0;
      ad_high_oe          <= 1'b0;
      rd_n_out            <= 1'b1;
      wr_n_out            <= 1'b1;
      strobe_oe           <= 1'b0;
      low_addr_strobe_out <= 1'b0;
      low_addr_strobe_oe  <= 1'b0;
      high_addr_strobe    <= 1'b0;
      local_request       <= 1'b0;
      int_n               <= 1'b1;
      disk_rdata          <= 8'h00;
      fifo_empty          <= 1'b1;
      fifo_full           <= 1'b0;
    end
    else
    begin
      ad_out     <= next_ad;
      ad_low_oe  <= next_low_oe;
      ad_high_oe <= next_high_oe;
      rd_n_out   <= !(next_state == dhb_pkg::DHB_DATA && !to_mem);
      wr_n_out   <= !(next_state == dhb_pkg::DHB_DATA && to_mem);
      strobe_oe  <= next_state != dhb_pkg::DHB_IDLE;
      low_addr_strobe_out <= next_state == dhb_pkg::DHB_ADDR_LO;
      low_addr_strobe_oe  <= next_state != dhb_pkg::DHB_IDLE;
      // shared pin: strobe in 32-bit, request otherwise
      high_addr_strobe    <= addr32 ? (next_state == dhb_pkg::DHB_ADDR_HI) : next_remote_req;
      local_request <= need_svc && !remote_track && !dma_busy;
      int_n         <= ~|(events & imask[3:0]);
      disk_rdata    <= fifo_head;
      fifo_empty    <= next_count == '0;
      fifo_full     <= next_count == (AW+1)'(DEPTH);
    end
  end

  select_ignored_a: assert property (@(posedge clk_sys) disable iff (srst)
    dma_busy |=> $stable(ctrl) && $stable(thresh) && $stable(imask))
    else $error("register write during dma");
  reset_fifo_a: assert property (@(posedge clk_sys)
    srst |=> fifo_empty && local_request == 1'b0) else $error("reset left fifo");
  sequence addr_phase_s;
    low_addr_strobe_out ##1 !low_addr_strobe_out;
  endsequence
  cycle_done_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(low_addr_strobe_out) |-> addr_phase_s ##1 strobe_oe) else $error("cycle cut");
  float_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
    $past(port_select_n) && $past(!any_grant) && $past(!dma_busy) |-> !ad_low_oe)
    else $error("low lines driven while idle");
  upper_driven_a: assert property (@(posedge clk_sys) disable iff (srst)
    $past(cpu_mode) && !$past(srst) |-> ad_high_oe) else $error("upper lines floated");
  irq_event_a: assert property (@(posedge clk_sys) disable iff (srst)
    event_pulse[0] && imask[0] ##1 imask[0] |=> !int_n) else $error("no interrupt");
  master_strobe_a: assert property (@(posedge clk_sys) disable iff (srst)
    !rd_n_out || !wr_n_out |-> strobe_oe) else $error("strobe undriven");
  hi_strobe_a: assert property (@(posedge clk_sys) disable iff (srst)
    high_addr_strobe && addr32 && $past(addr32) |=> low_addr_strobe_out)
    else $error("high strobe not followed");
endmodule
`default_nettype wire

// [test/dhb_sys_model.sv]
// system bus model: grants local dma, answers master reads and logs master writes
`timescale 1ns/1ps
`default_nettype none
module dhb_sys_model #(
  parameter int GRANT_DLY = 2
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        arb_en,
  input  wire logic        local_request,
  input  wire logic        strobe_oe,
  input  wire logic        rd_n_out,
  input  wire logic        wr_n_out,
  input  wire logic [15:0] ad_out,
  output logic             grant,
  output logic [15:0]      sys_ad,
  output logic             sys_drive,
  output logic [3:0]       wr_count,
  output logic [3:0][7:0]  wr_log
);
  logic [7:0] wait_cnt;
  logic       wr_prev;
  assign sys_drive = strobe_oe && !rd_n_out;
  always_ff @(posedge clk_sys)
  begin
    if (srst || !arb_en || !local_request)
    begin
      wait_cnt <= 8'h00;
      grant    <= 1'b0;
    end
    else if (wait_cnt < GRANT_DLY[7:0])
      wait_cnt <= wait_cnt + 8'h01;
    else
      grant <= 1'b1;
  end
  // released bus toggles every cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sys_ad <= 16'hFFFF;
    else
      sys_ad <= sys_drive ? 16'hC33C : ~sys_ad;
    wr_prev <= wr_n_out;
    if (srst)
      wr_count <= 4'h0;
    else if (strobe_oe && wr_prev && !wr_n_out)
    begin
      wr_log[wr_count[1:0]] <= ad_out[7:0];
      wr_count              <= wr_count + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
// self-checking bench of the host bus port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys, srst, port_select_n, rd_n_in, wr_n_in, tb_grant, lgrant, arb_en;
  logic rd_n_out, wr_n_out, strobe_oe, ad_low_oe, ad_high_oe, las_in, las_out, las_oe;
  logic hi_strobe, local_request, int_n, disk_push, disk_pop, fifo_empty, fifo_full;
  logic sys_drive, sys_grant;
  logic ads_seen = 1'b0;
  int hi_cnt = 0;
  int hi_base;
  logic [5:0] reg_select;
  logic [15:0] ad_in, ad_out, tb_ad, sys_ad;
  logic [3:0] event_pulse, wr_count;
  logic [3:0][7:0] wr_log;
  logic [7:0] disk_wdata, disk_rdata;
  int bad_count, checks_done;
  int cyc = 0;
  assign ad_in = sys_drive ? sys_ad : tb_ad;
  assign lgrant = tb_grant | sys_grant;
  dhb_host_bus DUT (.clk_sys(clk_sys), .srst(srst), .port_select_n(port_select_n),
    .reg_select(reg_select), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .rd_n_out(rd_n_out),
    .wr_n_out(wr_n_out), .strobe_oe(strobe_oe), .remote_grant(1'b0), .local_grant(lgrant),
    .ad_in(ad_in), .ad_out(ad_out), .ad_low_oe(ad_low_oe), .ad_high_oe(ad_high_oe),
    .low_addr_strobe_in(las_in), .low_addr_strobe_out(las_out), .low_addr_strobe_oe(las_oe),
    .high_addr_strobe(hi_strobe), .local_request(local_request), .int_n(int_n),
    .event_pulse(event_pulse), .disk_push(disk_push), .disk_wdata(disk_wdata),
    .disk_pop(disk_pop), .disk_rdata(disk_rdata), .fifo_empty(fifo_empty),
    .fifo_full(fifo_full));
  dhb_sys_model SYS (.clk_sys(clk_sys), .srst(srst), .arb_en(arb_en),
    .local_request(local_request), .strobe_oe(strobe_oe), .rd_n_out(rd_n_out),
    .wr_n_out(wr_n_out), .ad_out(ad_out), .grant(sys_grant), .sys_ad(sys_ad),
    .sys_drive(sys_drive), .wr_count(wr_count), .wr_log(wr_log));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (las_oe === 1'b1)
      ads_seen <= 1'b1;
    if (hi_strobe === 1'b1)
      hi_cnt <= hi_cnt + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    reg_select <= a;
    tb_ad      <= {8'h00, d};
    @(posedge clk_sys);
    wr_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys);
    wr_n_in <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input logic ps);
    port_select_n <= ps;
    reg_select    <= a;
    @(posedge clk_sys);
    rd_n_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    if (ps)
      chk(ad_low_oe, 0, "deselected drive");
    else
    begin
      chk(ad_out[7:0], exp, "read data");
      chk({ad_low_oe, ad_high_oe}, 3, "read drive");
    end
    @(posedge clk_sys);
    rd_n_in       <= 1'b1;
    port_select_n <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic push(input logic [7:0] d);
    disk_push  <= 1'b1;
    disk_wdata <= d;
    @(posedge clk_sys);
    disk_push <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic dma_run(input logic [7:0] ctl, input logic [3:0] n);
    push(8'h3C);
    push(8'hC3);
    wr_reg(dhb_pkg::REG_CTRL, ctl);
    arb_en <= 1'b1;
    repeat (400) if (wr_count !== n) @(posedge clk_sys);
    arb_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(wr_log[n-4'h2], 8'h3C, "dma byte 0");
    chk(wr_log[n-4'h1], 8'hC3, "dma byte 1");
    chk(fifo_empty, 1, "fifo drained");
    wr_reg(dhb_pkg::REG_CTRL, 8'h00);
  endtask
  initial
  begin
    srst <= 1'b1; port_select_n <= 1'b1; reg_select <= 6'h00; rd_n_in <= 1'b1;
    wr_n_in <= 1'b1; tb_grant <= 1'b0; arb_en <= 1'b0; tb_ad <= 16'h0000;
    las_in <= 1'b1; event_pulse <= 4'h0; disk_push <= 1'b0; disk_pop <= 1'b0;
    disk_wdata <= 8'h00;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk({int_n, fifo_empty, ad_low_oe, strobe_oe}, 4'hC, "reset outputs");
    rd_chk(dhb_pkg::REG_ID, dhb_pkg::ID_VALUE, 1'b0);
    wr_reg(dhb_pkg::REG_CTRL, dhb_pkg::CTRL_RST);
    wr_reg(dhb_pkg::REG_THRESH, 8'h05);
    rd_chk(dhb_pkg::REG_THRESH, 8'h05, 1'b0);
    port_select_n <= 1'b1;
    wr_reg(dhb_pkg::REG_THRESH, 8'h11);
    rd_chk(dhb_pkg::REG_THRESH, 8'h00, 1'b1);
    rd_chk(dhb_pkg::REG_THRESH, 8'h05, 1'b0);
    reg_select <= dhb_pkg::REG_ID;
    @(posedge clk_sys);
    las_in <= 1'b0;
    rd_chk(dhb_pkg::REG_THRESH, dhb_pkg::ID_VALUE, 1'b0);
    las_in <= 1'b1;
    wr_reg(dhb_pkg::REG_IMASK, 8'h0F);
    for (int i = 0; i < 4; i++)
    begin
      event_pulse <= 4'h1 << i;
      @(posedge clk_sys);
      event_pulse <= 4'h0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk(int_n, 0, "event raises int");
      rd_chk(dhb_pkg::REG_STATUS, 8'h10 | (8'h01 << i), 1'b0);
      wr_reg(dhb_pkg::REG_STATUS, 8'h01 << i);
      #1;
      chk(int_n, 1, "event cleared");
    end
    port_select_n <= 1'b1;
    tb_grant      <= 1'b1;
    wr_reg(dhb_pkg::REG_FIFO, 8'hA5);
    tb_grant <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({fifo_empty, disk_rdata}, 16'h00A5, "slave write to fifo");
    port_select_n <= 1'b0;
    srst          <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(fifo_empty, 1, "reset empties fifo");
    rd_chk(dhb_pkg::REG_THRESH, 8'h05, 1'b0);
    for (int i = 0; i < 4; i++)
      wr_reg(dhb_pkg::REG_ADDR0 + 6'(i), 8'h10 * 8'(i + 1));
    wr_reg(dhb_pkg::REG_THRESH, 8'h01);
    wr_reg(dhb_pkg::REG_IMASK, 8'h00);
    dma_run(8'h13, 4'h2);
    chk(ads_seen, 1, "low address strobe driven");
    hi_base = hi_cnt;
    dma_run(8'h1B, 4'h4);
    chk(16'(hi_cnt - hi_base), 16'h0002, "high address strobe");
    tally_and_finish();
  end
endmodule
`default_nettype wire
